// ### usbirq_pkg.sv
// package: register map, field layout and shared types for the usb interrupt logic
package usbirq_pkg;

   // ----------------------------------------
   // register byte addresses
   // ----------------------------------------
   localparam logic [11:0] STATUS_FLAGS_ADDR   = 12'h000;
   localparam logic [11:0] STATUS_ENABLES_ADDR = 12'h004;
   localparam logic [11:0] ERROR_FLAGS_ADDR    = 12'h008;
   localparam logic [11:0] ERROR_ENABLES_ADDR  = 12'h00c;
   localparam logic [11:0] CONTROL_ADDR        = 12'h010;
   localparam logic [11:0] DEVICE_ADDR_ADDR    = 12'h014;

   // ----------------------------------------
   // status flag bit positions
   // ----------------------------------------
   localparam int BUS_RESET_BIT   = 0;
   localparam int ERR_SUMMARY_BIT = 1;
   localparam int ACTIVITY_BIT    = 2;
   localparam int TRN_DONE_BIT    = 3;
   localparam int IDLE_BIT        = 4;
   localparam int STALL_BIT       = 5;
   localparam int FRAME_START_BIT = 6;

   // ----------------------------------------
   // implemented bit masks and reset values
   // ----------------------------------------
   localparam logic [7:0] STATUS_IMPL_MASK = 8'h7f;
   localparam logic [7:0] STATUS_WR_MASK   = 8'h7d;
   localparam logic [7:0] ERROR_IMPL_MASK  = 8'h9f;
   localparam logic [7:0] REG8_RESET       = 8'h00;
   localparam logic [6:0] DEV_ADDR_RESET   = 7'h00;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int IDLE_TIME_MS  = 3;
   localparam int IDLE_CYCLES   = (IDLE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic frame_start;
      logic stall_sent;
      logic trn_done;
      logic bus_reset;
      logic bus_active;
   } usbirq_event_t;

   typedef struct packed {
      logic stuffing;
      logic turnaround_timeout;
      logic field_size;
      logic data_crc;
      logic token_crc;
      logic packet_id;
   } usbirq_error_t;

endpackage : usbirq_pkg

// ### usbirq_top.sv
// module: two-level usb interrupt logic with an ahb-lite register slave
//
// Function
// RULE_01 - one irq line from enabled status flags
// RULE_02 - irq is or of enable-gated flags
// RULE_03 - flags latch regardless of enable bits
// RULE_04 - flags hold until software writes zero
// RULE_05 - software write of one sets flag
// RULE_06 - enables sit at matching bit positions
// RULE_07 - error summary is or of masked errors
// RULE_08 - error summary is read-only, follows errors
// RULE_09 - bit 6 frame start, bit 5 stall
// RULE_10 - bit 4 after 3 ms idle
// RULE_11 - bit 3 transaction done, clear advances fifo
// RULE_12 - bit 2 on d+/d- activity
// RULE_13 - bit 0 bus reset, address zeroed
// RULE_14 - activity clear ignored while suspended/waking
// RULE_15 - activity flag once per resume
// RULE_16 - error flags set immediately on detection
// RULE_17 - error bit 7 bit stuff violation
// RULE_18 - error bit 4 turnaround timeout
// RULE_19 - error bit 3 data field size
// RULE_20 - error bit 2 crc16, bit 1 crc5
// RULE_21 - error bit 0 pid check failure
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module usbirq_top #(
   parameter int IDLE_CYCLES = usbirq_pkg::IDLE_CYCLES,
   parameter int WAKE_CYCLES = 4
) (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic      [31:0]               hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   input  wire usbirq_pkg::usbirq_event_t events,
   input  wire usbirq_pkg::usbirq_error_t errors,
   input  wire logic                      line_idle,
   output logic                           core_usb_irq_flag,
   output logic                           fifo_advance,
   output logic      [6:0]                device_address_reg,
   output logic                           suspend_control_bit
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic        wr_pend;
      logic        rd_pend;
      logic [5:0]  word;
      logic [31:0] rdata;
      logic [7:0]  st_flags;
      logic [7:0]  st_en;
      logic [7:0]  er_flags;
      logic [7:0]  er_en;
      logic [6:0]  dev_addr;
      logic        suspend;
      logic [3:0]  wake_cnt;
      logic [31:0] idle_cnt;
      logic        idle_seen;
      logic        fifo_adv;
      logic        irq;
   } usbirq_state_t;

   usbirq_state_t s_q;
   usbirq_state_t s_d;

   logic [7:0] er_set;
   logic [7:0] st_set;
   logic [7:0] wbyte;
   logic       act_clr_ok;

   // ----------------------------------------
   // event collection
   // ----------------------------------------
   always_comb begin
      er_set = 8'h00;
      er_set[7] = errors.stuffing;                  // RULE_17
      er_set[4] = errors.turnaround_timeout;        // RULE_18
      er_set[3] = errors.field_size;                // RULE_19
      er_set[2] = errors.data_crc;                  // RULE_20
      er_set[1] = errors.token_crc;                 // RULE_20
      er_set[0] = errors.packet_id;                 // RULE_21
      st_set = 8'h00;
      st_set[usbirq_pkg::FRAME_START_BIT] = events.frame_start;  // RULE_09
      st_set[usbirq_pkg::STALL_BIT]       = events.stall_sent;   // RULE_09
      st_set[usbirq_pkg::TRN_DONE_BIT]    = events.trn_done;     // RULE_11
      st_set[usbirq_pkg::BUS_RESET_BIT]   = events.bus_reset;    // RULE_13
      // only one activity flag per resume from idle
      st_set[usbirq_pkg::ACTIVITY_BIT]    = events.bus_active & s_q.idle_seen; // RULE_12 RULE_15
      st_set[usbirq_pkg::IDLE_BIT] = (s_q.idle_cnt == 32'(IDLE_CYCLES - 1)) & line_idle; // RULE_10
   end

   assign wbyte      = hwdata[7:0];
   assign act_clr_ok = ~s_q.suspend & (s_q.wake_cnt == 4'h0); // RULE_14

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.fifo_adv = 1'b0;

      // address phase capture
      s_d.wr_pend = 1'b0;
      s_d.rd_pend = 1'b0;
      if (hsel && hready && htrans[1]) begin
         s_d.wr_pend = hwrite;
         s_d.rd_pend = ~hwrite;
         s_d.word    = haddr[7:2];
      end

      // idle timer counts continuous idle
      if (!line_idle) begin
         s_d.idle_cnt = 32'h0;
      // saturate one past the match so a long idle raises the flag only once
      end else if (s_q.idle_cnt != 32'(IDLE_CYCLES)) begin
         s_d.idle_cnt = s_q.idle_cnt + 32'h1;
      end
      if (st_set[usbirq_pkg::IDLE_BIT]) begin
         s_d.idle_seen = 1'b1;                       // RULE_15
      end
      if (st_set[usbirq_pkg::ACTIVITY_BIT]) begin
         s_d.idle_seen = 1'b0;                       // RULE_15
      end

      if (s_q.wake_cnt != 4'h0) begin
         s_d.wake_cnt = s_q.wake_cnt - 4'h1;
      end

      // software writes in data phase
      if (s_q.wr_pend) begin
         case ({s_q.word, 2'b00})
            usbirq_pkg::STATUS_FLAGS_ADDR[7:0]: begin
               // zero clears, one sets; summary bit untouched
               s_d.st_flags = wbyte & s_q.st_flags & usbirq_pkg::STATUS_WR_MASK; // RULE_04
               s_d.st_flags = s_d.st_flags | (wbyte & usbirq_pkg::STATUS_WR_MASK); // RULE_05
               if (!act_clr_ok) begin
                  s_d.st_flags[usbirq_pkg::ACTIVITY_BIT] =
                     s_q.st_flags[usbirq_pkg::ACTIVITY_BIT] | wbyte[usbirq_pkg::ACTIVITY_BIT]; // RULE_14
               end
               if (s_q.st_flags[usbirq_pkg::TRN_DONE_BIT] &&
                   !wbyte[usbirq_pkg::TRN_DONE_BIT]) begin
                  s_d.fifo_adv = 1'b1;               // RULE_11
               end
            end
            usbirq_pkg::STATUS_ENABLES_ADDR[7:0]: begin
               s_d.st_en = wbyte & usbirq_pkg::STATUS_IMPL_MASK; // RULE_06
            end
            usbirq_pkg::ERROR_FLAGS_ADDR[7:0]: begin
               s_d.er_flags = wbyte & s_q.er_flags; // RULE_04
            end
            usbirq_pkg::ERROR_ENABLES_ADDR[7:0]: begin
               s_d.er_en = wbyte & usbirq_pkg::ERROR_IMPL_MASK; // RULE_06
            end
            usbirq_pkg::CONTROL_ADDR[7:0]: begin
               if (s_q.suspend && !wbyte[0]) begin
                  s_d.wake_cnt = 4'(WAKE_CYCLES);
               end
               s_d.suspend = wbyte[0];
            end
            usbirq_pkg::DEVICE_ADDR_ADDR[7:0]: begin
               s_d.dev_addr = wbyte[6:0];
            end
            default: begin
            end
         endcase
      end

      // hardware set wins over software clear
      s_d.er_flags = s_d.er_flags | er_set;          // RULE_03 RULE_16
      s_d.st_flags = s_d.st_flags | st_set;          // RULE_03
      if (events.bus_reset) begin
         s_d.dev_addr = usbirq_pkg::DEV_ADDR_RESET;  // RULE_13
      end

      // summary tracks masked errors, never software
      s_d.st_flags[usbirq_pkg::ERR_SUMMARY_BIT] = |(s_d.er_flags & s_d.er_en); // RULE_07 RULE_08
      s_d.st_flags[7] = 1'b0;
      s_d.irq = |(s_d.st_flags & s_d.st_en);         // RULE_01 RULE_02

      // read data
      s_d.rdata = 32'h0;
      if (hsel && hready && htrans[1] && !hwrite) begin
         case ({haddr[7:2], 2'b00})
            usbirq_pkg::STATUS_FLAGS_ADDR[7:0]:   s_d.rdata = {24'h0, s_d.st_flags};
            usbirq_pkg::STATUS_ENABLES_ADDR[7:0]: s_d.rdata = {24'h0, s_d.st_en};
            usbirq_pkg::ERROR_FLAGS_ADDR[7:0]:    s_d.rdata = {24'h0, s_d.er_flags};
            usbirq_pkg::ERROR_ENABLES_ADDR[7:0]:  s_d.rdata = {24'h0, s_d.er_en};
            usbirq_pkg::CONTROL_ADDR[7:0]:        s_d.rdata = {31'h0, s_d.suspend};
            usbirq_pkg::DEVICE_ADDR_ADDR[7:0]:    s_d.rdata = {25'h0, s_d.dev_addr};
            default:                              s_d.rdata = 32'h0;
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign hrdata              = s_q.rdata;
   assign hreadyout           = 1'b1;
   assign hresp               = 1'b0;
   assign core_usb_irq_flag   = s_q.irq;
   assign fifo_advance        = s_q.fifo_adv;
   assign device_address_reg  = s_q.dev_addr;
   assign suspend_control_bit = s_q.suspend;

endmodule : usbirq_top

// ### usbirq_engine_model.sv
// partner: protocol engine model driving event, error and idle lines
`timescale 1ns/1ps
module usbirq_engine_model (
   input wire logic                  hclk,
   output usbirq_pkg::usbirq_event_t events,
   output usbirq_pkg::usbirq_error_t errors,
   output logic                      line_idle
);
   // ----------------
   // stimulus tasks
   // ----------------
   initial begin
      events    = '0;
      errors    = '0;
      line_idle = 1'b0;
   end
   // one-cycle pulses, the tightest case the flags must catch
   task automatic ev(input usbirq_pkg::usbirq_event_t e, input usbirq_pkg::usbirq_error_t r);
      @(posedge hclk);
      events <= e;
      errors <= r;
      @(posedge hclk);
      events <= '0;
      errors <= '0;
      #1;
   endtask : ev
   task automatic idle(input int n);
      @(posedge hclk);
      line_idle <= 1'b1;
      repeat (n) @(posedge hclk);
      line_idle <= 1'b0;
   endtask : idle
endmodule : usbirq_engine_model

// ### usbirq_assertions.sv
// checker: port-level behaviour of the usb interrupt logic
`timescale 1ns/1ps
module usbirq_chk (
   input wire logic                      hclk,
   input wire logic                      hresetn,
   input wire logic                      hsel,
   input wire logic [31:0]               haddr,
   input wire logic [1:0]                htrans,
   input wire logic                      hwrite,
   input wire logic [31:0]               hwdata,
   input wire logic                      hready,
   input wire usbirq_pkg::usbirq_event_t events,
   input wire usbirq_pkg::usbirq_error_t errors,
   input wire logic                      line_idle,
   input wire logic                      core_usb_irq_flag,
   input wire logic                      fifo_advance,
   input wire logic [6:0]                device_address_reg
);
   // ----------------
   // shadow of enable writes
   // ----------------
   logic       wr_q;
   logic [7:0] addr_q;
   logic [7:0] se_q;
   logic [7:0] ee_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q   <= 1'b0;
         addr_q <= 8'h00;
         se_q   <= 8'h00;
         ee_q   <= 8'h00;
      end else begin
         wr_q   <= hsel & hready & htrans[1] & hwrite;
         addr_q <= haddr[7:0];
         if (wr_q && addr_q == 8'h04) se_q <= hwdata[7:0];
         if (wr_q && addr_q == 8'h0c) ee_q <= hwdata[7:0];
      end
   end
   // ----------------
   // assertions
   // ----------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_addr_zeroed: assert property (events.bus_reset |=> device_address_reg == 7'h00)
      else $error("address not zeroed");
   a_addr_source: assert property ($changed(device_address_reg) |->
      $past(events.bus_reset || (wr_q && addr_q == 8'h14))) else $error("address moved");
   a_irq_hold: assert property ($fell(core_usb_irq_flag) |-> $past(wr_q))
      else $error("irq dropped without write");
   a_irq_cause: assert property ($rose(core_usb_irq_flag) |->
      $past(|events || |errors || wr_q || line_idle)) else $error("irq without cause");
   a_fifo_cause: assert property (fifo_advance |->
      $past(wr_q && addr_q == 8'h00 && !hwdata[3])) else $error("stray fifo advance");
   a_masked_quiet: assert property (se_q[6:0] == 7'h00 |-> !core_usb_irq_flag)
      else $error("irq while all masked");
   a_event_irq: assert property (|(events[4:1] & {se_q[6], se_q[5], se_q[3], se_q[0]})
      |=> core_usb_irq_flag) else $error("enabled event gave no irq");
   a_error_irq: assert property (se_q[1] && |(errors & {ee_q[7], ee_q[4:0]})
      |=> core_usb_irq_flag) else $error("enabled error gave no irq");
   c_fifo_pulse: cover property (fifo_advance);
   c_irq_rise: cover property ($rose(core_usb_irq_flag));
   c_irq_fall: cover property ($fell(core_usb_irq_flag));
endmodule : usbirq_chk
bind usbirq_top usbirq_chk u_chk (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .events, .errors,
   .line_idle, .core_usb_irq_flag, .fifo_advance, .device_address_reg
);

// ### tb_top.sv
// testbench: register-level checks of the usb interrupt logic
`timescale 1ns/1ps
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin err_count++; \
   $display("[FAIL] %s exp %h got %h", nm, e, s); end end
module tb_top;
   // ----------------
   // signals and instances
   // ----------------
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata;
   logic [31:0] rd_q;
   logic        hreadyout;
   logic        irq;
   logic        hresp;
   logic        fifo_adv;
   logic        susp;
   logic        line_idle;
   usbirq_pkg::usbirq_event_t events;
   usbirq_pkg::usbirq_error_t errors;
   int          err_count = 0;
   int          tests_run = 0;
   int          sbit[5] = '{0, 0, 3, 5, 6};
   int          ebit[6] = '{0, 1, 2, 3, 4, 7};
   logic [7:0]  regs[7] = '{8'h40, 8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14};
   usbirq_top #(.IDLE_CYCLES(20), .WAKE_CYCLES(4)) dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .events, .errors, .line_idle,
      .core_usb_irq_flag(irq), .fifo_advance(fifo_adv), .device_address_reg(),
      .suspend_control_bit(susp)
   );
   usbirq_engine_model eng (.hclk, .events, .errors, .line_idle);
   initial forever #5 hclk = ~hclk;
   // read data sampled before the closing edge updates it
   always @(posedge hclk) rd_q <= hrdata;
   // ----------------
   // bus tasks
   // ----------------
   task automatic end_of_test;
      $display("errors %0d compares %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   task automatic wt;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin err_count++; end_of_test; end
   endtask : wt
   task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      wt;
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      wt;
      #1;
   endtask : xfer
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      xfer(a, 1'b0, 8'h00);
      `CHK(nm, {24'h0, e}, rd_q)
   endtask : rd
   // ----------------
   // scenarios
   // ----------------
   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      end_of_test;
   end
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(8'h40, 1'b1, 8'hff);
      foreach (regs[i]) rd(regs[i], 8'h00, "reset and unmapped");
      xfer(8'h14, 1'b1, 8'h2a);
      rd(8'h14, 8'h2a, "address write");
      for (int i = 1; i < 5; i++) begin
         eng.ev(5'(1 << i), 6'h00);
         rd(8'h00, 8'(1 << sbit[i]), "status flag");
         `CHK("irq masked", 1'b0, irq)
         xfer(8'h00, 1'b1, 8'h00);
         `CHK("fifo advance", (i == 2), fifo_adv)
         rd(8'h00, 8'h00, "status clear");
      end
      rd(8'h14, 8'h00, "address zeroed");
      xfer(8'h04, 1'b1, 8'h7f);
      eng.ev(5'h10, 6'h00);
      `CHK("irq raised", 1'b1, irq)
      xfer(8'h04, 1'b1, 8'h00);
      `CHK("irq gated", 1'b0, irq)
      xfer(8'h00, 1'b1, 8'hff);
      rd(8'h00, 8'h7d, "soft set");
      xfer(8'h00, 1'b1, 8'h00);
      for (int i = 0; i < 6; i++) begin
         eng.ev(5'h00, 6'(1 << i));
         rd(8'h08, 8'(1 << ebit[i]), "error flag");
         rd(8'h00, 8'h00, "summary masked");
         xfer(8'h08, 1'b1, 8'hff);
         rd(8'h08, 8'(1 << ebit[i]), "error one kept");
         xfer(8'h08, 1'b1, 8'h00);
      end
      xfer(8'h0c, 1'b1, 8'hff);
      rd(8'h0c, 8'h9f, "error enables");
      xfer(8'h04, 1'b1, 8'h02);
      eng.ev(5'h00, 6'h20);
      `CHK("irq error", 1'b1, irq)
      xfer(8'h00, 1'b1, 8'h00);
      rd(8'h00, 8'h02, "summary held");
      xfer(8'h08, 1'b1, 8'h00);
      rd(8'h00, 8'h00, "summary follows");
      xfer(8'h04, 1'b1, 8'h00);
      eng.ev(5'h01, 6'h00);
      eng.idle(18);
      rd(8'h00, 8'h00, "no early idle");
      eng.idle(24);
      rd(8'h00, 8'h10, "idle flag");
      eng.ev(5'h01, 6'h00);
      xfer(8'h10, 1'b1, 8'h01);
      `CHK("suspend bit", 1'b1, susp)
      xfer(8'h00, 1'b1, 8'h00);
      rd(8'h00, 8'h04, "clear in suspend");
      xfer(8'h10, 1'b1, 8'h00);
      repeat (6) @(posedge hclk);
      xfer(8'h00, 1'b1, 8'h00);
      rd(8'h00, 8'h00, "activity clear");
      eng.ev(5'h01, 6'h00);
      rd(8'h00, 8'h00, "activity once");
      `CHK("okay response", 1'b0, hresp)
      end_of_test;
   end
endmodule : tb_top
